// ==== core/ebp_pkg.sv ====
// Package for the external bus pin sharing block: register map, fields, carriers
package ebp_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [3:0] EBP_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] EBP_ADDR_UACTL  = 4'h4;
  localparam logic [3:0] EBP_ADDR_STATUS = 4'h8;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int EBP_CTRL_BUS_EN  = 0;
  localparam int EBP_CTRL_WIDE    = 1;
  localparam int EBP_CTRL_CLK_EN  = 2;
  localparam int EBP_CTRL_RDY_EN  = 3;
  localparam int EBP_CTRL_HOLD_EN = 4;
  localparam int EBP_CTRL_WRH_EN  = 5;
  localparam int EBP_CTRL_W       = 6;

  localparam logic [5:0]  EBP_CTRL_RST  = 6'h00;
  localparam logic [7:0]  EBP_UACTL_RST = 8'h00;
  localparam logic [1:0]  EBP_RESP_OK   = 2'h0;
  localparam logic [1:0]  EBP_RESP_ERR  = 2'h2;

  // Status register fields
  localparam int EBP_STAT_RDY  = 0;
  localparam int EBP_STAT_HREQ = 1;
  localparam int EBP_STAT_HACK = 2;

  // Function enables decoded from the control register
  typedef struct packed {
    logic bus_en;
    logic wide;
    logic clk_en;
    logic rdy_en;
    logic hold_en;
    logic wrh_en;
  } ebp_ctrl_t;

  // One tri-state pin group
  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } ebp_pins8_t;

endpackage

// ==== core/ebp_pin_share.sv ====
// External bus pin sharing: per-pin selection between port logic and bus functions
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Upper data pins belong to the port in 8-bit external bus mode.
// - Upper data pins carry bidirectional bus data 8..15 in 16-bit mode.
// - Upper-address pins whose control bit selects port act as port bits.
// - Address 16..23 driven only with bus active and control bit selecting address.
// - Clock output pin drives clock when enabled, else returns to port.
// - Ready pin sampled as ready only when enabled, otherwise port bit.
// - Hold acknowledge driven when hold enabled, otherwise port bit.
// - Hold request taken from pin when hold enabled, otherwise port bit.
// - Upper write strobe driven only in 16-bit mode with strobe enabled.
module ebp_pin_share
  import ebp_pkg::*;
(
  input  wire  logic        clk_sys_i,
  input  wire  logic        rstn_i,
  input  wire  logic        ce_i,
  // AXI4-Lite slave
  input  wire  logic [3:0]  s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [3:0]  s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  // Port logic side
  input  wire  logic [7:0]  upper_data_port_bits_o_i,
  input  wire  logic [7:0]  upper_data_port_bits_oe_i,
  output logic [7:0]        upper_data_port_bits_in_o,
  input  wire  logic [7:0]  upper_address_port_bits_o_i,
  input  wire  logic [7:0]  upper_address_port_bits_oe_i,
  output logic [7:0]        upper_address_port_bits_in_o,
  input  wire  logic [4:0]  ctl_port_bits_o_i,
  input  wire  logic [4:0]  ctl_port_bits_oe_i,
  output logic [4:0]        ctl_port_bits_in_o,
  // Bus controller side
  input  wire  logic [7:0]  upper_data_bus_bits_o_i,
  input  wire  logic        upper_data_bus_drive_i,
  output logic [7:0]        upper_data_bus_bits_in_o,
  input  wire  logic [7:0]  upper_address_bus_bits_i,
  input  wire  logic        bus_clock_i,
  output logic              ext_ready_o,
  input  wire  logic        hold_acknowledge_out_i,
  output logic              hold_request_in_o,
  input  wire  logic        upper_byte_write_strobe_i,
  // Pads
  input  wire  logic [7:0]  pad_data_i,
  output logic [7:0]        pad_data_o,
  output logic [7:0]        pad_data_oe_o,
  input  wire  logic [7:0]  pad_addr_i,
  output logic [7:0]        pad_addr_o,
  output logic [7:0]        pad_addr_oe_o,
  input  wire  logic [4:0]  pad_ctl_i,
  output logic [4:0]        pad_ctl_o,
  output logic [4:0]        pad_ctl_oe_o
);

  // ****************************************
  // Control registers
  // ****************************************
  logic [EBP_CTRL_W-1:0] ctrl_q;
  logic [7:0]            uactl_q;
  ebp_ctrl_t             cfg;

  // Field by field, so register bit positions do not hang on struct member order
  assign cfg = '{bus_en:  ctrl_q[EBP_CTRL_BUS_EN],
                 wide:    ctrl_q[EBP_CTRL_WIDE],
                 clk_en:  ctrl_q[EBP_CTRL_CLK_EN],
                 rdy_en:  ctrl_q[EBP_CTRL_RDY_EN],
                 hold_en: ctrl_q[EBP_CTRL_HOLD_EN],
                 wrh_en:  ctrl_q[EBP_CTRL_WRH_EN]};

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  logic        aw_q;
  logic        w_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic        wstrb0_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        wr_go;

  assign s_axi_awready = ~aw_q & ~bvalid_q;
  assign s_axi_wready  = ~w_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_go         = aw_q & w_q & ~bvalid_q;

  // Capture address and data in either order
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q  <= 32'h0;
      wstrb0_q <= 1'b0;
    end else if (ce_i) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q      <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  // Register update and write response
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q   <= EBP_CTRL_RST;
      uactl_q  <= EBP_UACTL_RST;
      bvalid_q <= 1'b0;
      bresp_q  <= EBP_RESP_OK;
    end else if (ce_i) begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= EBP_RESP_OK;
        case (awaddr_q)
          EBP_ADDR_CTRL: begin
            if (wstrb0_q) ctrl_q <= wdata_q[EBP_CTRL_W-1:0];
          end
          EBP_ADDR_UACTL: begin
            if (wstrb0_q) uactl_q <= wdata_q[7:0];
          end
          EBP_ADDR_STATUS: ;
          default: bresp_q <= EBP_RESP_ERR;
        endcase
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [2:0]  status;

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Live function pin levels seen by the bus
  assign status = {cfg.hold_en & hold_acknowledge_out_i, hold_request_in_o, ext_ready_o};

  // Read data registered one cycle after address
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= EBP_RESP_OK;
    end else if (ce_i) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        rresp_q  <= EBP_RESP_OK;
        case (s_axi_araddr)
          EBP_ADDR_CTRL:   rdata_q <= {26'h0, ctrl_q};
          EBP_ADDR_UACTL:  rdata_q <= {24'h0, uactl_q};
          EBP_ADDR_STATUS: rdata_q <= {29'h0, status};
          default: begin
            rdata_q <= 32'h0;
            rresp_q <= EBP_RESP_ERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pin ownership
  // ****************************************
  logic       data_bus_own;
  logic [7:0] addr_bus_own;
  logic       clk_own;
  logic       wrh_own;

  assign data_bus_own = cfg.bus_en & cfg.wide;
  assign clk_own      = cfg.clk_en;
  assign wrh_own      = cfg.bus_en & cfg.wide & cfg.wrh_en;

  // Upper data byte: bus data in 16-bit mode, port otherwise
  always_comb begin
    if (data_bus_own) begin
      pad_data_o    = upper_data_bus_bits_o_i;
      pad_data_oe_o = {8{upper_data_bus_drive_i}};
    end else begin
      pad_data_o    = upper_data_port_bits_o_i;
      pad_data_oe_o = upper_data_port_bits_oe_i;
    end
  end
  assign upper_data_bus_bits_in_o  = data_bus_own ? pad_data_i : 8'h00;
  assign upper_data_port_bits_in_o = pad_data_i;

  // Upper address byte selected bit by bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_addr
      assign addr_bus_own[gi]  = cfg.bus_en & uactl_q[gi];
      assign pad_addr_o[gi]    = addr_bus_own[gi] ? upper_address_bus_bits_i[gi]
                                                  : upper_address_port_bits_o_i[gi];
      assign pad_addr_oe_o[gi] = addr_bus_own[gi] | upper_address_port_bits_oe_i[gi];
    end
  endgenerate
  assign upper_address_port_bits_in_o = pad_addr_i;

  // Control pins: clock, ready, hold ack, hold req, upper strobe
  always_comb begin
    pad_ctl_o    = ctl_port_bits_o_i;
    pad_ctl_oe_o = ctl_port_bits_oe_i;
    if (clk_own) begin
      pad_ctl_o[0]    = bus_clock_i;
      pad_ctl_oe_o[0] = 1'b1;
    end
    if (cfg.rdy_en) begin
      pad_ctl_oe_o[1] = 1'b0;
    end
    if (cfg.hold_en) begin
      pad_ctl_o[2]    = hold_acknowledge_out_i;
      pad_ctl_oe_o[2] = 1'b1;
      pad_ctl_oe_o[3] = 1'b0;
    end
    if (wrh_own) begin
      pad_ctl_o[4]    = upper_byte_write_strobe_i;
      pad_ctl_oe_o[4] = 1'b1;
    end
  end
  assign ext_ready_o        = cfg.rdy_en ? pad_ctl_i[1] : 1'b1;
  assign hold_request_in_o  = cfg.hold_en & pad_ctl_i[3];
  assign ctl_port_bits_in_o = pad_ctl_i;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  data_port_a: assert property (!data_bus_own |-> pad_data_oe_o == upper_data_port_bits_oe_i)
    else $error("upper data pins not with port in 8-bit mode");
  data_bus_a: assert property (cfg.bus_en && cfg.wide |-> pad_data_o == upper_data_bus_bits_o_i)
    else $error("upper data pins not carrying bus data");
  addr_port_a: assert property (!cfg.bus_en |-> pad_addr_o == upper_address_port_bits_o_i)
    else $error("address pin not a port bit");
  addr_bus_a: assert property (cfg.bus_en |-> (pad_addr_oe_o & uactl_q) == uactl_q)
    else $error("address pins not driven");
  addr_own_a: assert property (cfg.bus_en |-> ((pad_addr_o ^ upper_address_bus_bits_i) & uactl_q) == 8'h00)
    else $error("port data leaked onto address pin");
  clk_out_a: assert property (cfg.clk_en |-> pad_ctl_oe_o[0] && pad_ctl_o[0] == bus_clock_i)
    else $error("clock pin not driving clock");
  ready_in_a: assert property (!cfg.rdy_en |-> ext_ready_o)
    else $error("ready taken while disabled");
  hold_ack_a: assert property (cfg.hold_en |-> pad_ctl_oe_o[2] && !pad_ctl_oe_o[3])
    else $error("hold pins wrong direction");
  hold_req_a: assert property (!cfg.hold_en |-> !hold_request_in_o)
    else $error("hold request seen while disabled");
  wrh_a: assert property (!cfg.wide |-> pad_ctl_oe_o[4] == ctl_port_bits_oe_i[4])
    else $error("upper strobe driven in 8-bit mode");
  wr_resp_a: assert property (wr_go && ce_i |=> bvalid_q)
    else $error("write not answered");

endmodule
`default_nettype wire

// ==== tb/ebp_ext_model.sv ====
// Far-side model: external memory and peripherals on the shared pins
`timescale 1ns/1ns
`default_nettype none
module ebp_ext_model (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] dat_i,
  input  wire logic [7:0] dat_oe_i,
  input  wire logic [7:0] adr_i,
  input  wire logic [7:0] adr_oe_i,
  input  wire logic [4:0] ctl_i,
  input  wire logic [4:0] ctl_oe_i,
  input  wire logic [7:0] mem_i,
  input  wire logic       mem_en_i,
  input  wire logic       rdy_i,
  input  wire logic       hrq_i,
  output logic      [7:0] dat_o,
  output logic      [7:0] adr_o,
  output logic      [4:0] ctl_o
);
  logic [7:0] flip_q = 8'h96;
  // Undriven lines with no far-side source change every cycle
  always @(posedge clk_sys_i) flip_q <= ~flip_q;
  // Memory answers on data lines the device let go
  assign dat_o = (dat_oe_i & dat_i) | (~dat_oe_i & (mem_en_i ? mem_i : flip_q));
  assign adr_o = (adr_oe_i & adr_i) | (~adr_oe_i & flip_q);
  // Ready and hold request come from the far side
  assign ctl_o = (ctl_oe_i & ctl_i) |
                 (~ctl_oe_i & {flip_q[4], hrq_i, flip_q[2], rdy_i, flip_q[0]});
endmodule
`default_nettype wire

// ==== tb/external_bus_pin_sharing_test.sv ====
// Testbench for the external bus pin sharing block
`timescale 1ns/1ns
`default_nettype none
module external_bus_pin_sharing_test;
  import ebp_pkg::*;
  logic        clk, rstn, awv, wv, bry, arv, rry, awr, wr, bv, arr, rv, drv, mdrv;
  logic        rdy, hold_request_in, bclk, hold_acknowledge_out, upper_byte_write_strobe, xrdy, xhrq;
  logic [3:0]  awa, ara, ws;
  logic [31:0] wd, rd, d;
  logic [1:0]  br, rr, r;
  logic [7:0]  pdo, pdoe, pao, paoe, bdo, bao, mdat, pdi, pd_o, pd_oe, pai, pa_o, pa_oe;
  logic [7:0]  udin, uain, bdin;
  logic [4:0]  pco, pcoe, pci, pc_o, pc_oe, cin;
  int          num_errors, n_tests;

  ebp_pin_share ebp_pin_share_inst (.clk_sys_i(clk), .rstn_i(rstn), .ce_i(1'b1),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry), .upper_data_port_bits_o_i(pdo), .upper_data_port_bits_oe_i(pdoe),
    .upper_data_port_bits_in_o(udin), .upper_address_port_bits_o_i(pao),
    .upper_address_port_bits_oe_i(paoe), .upper_address_port_bits_in_o(uain),
    .ctl_port_bits_o_i(pco), .ctl_port_bits_oe_i(pcoe), .ctl_port_bits_in_o(cin),
    .upper_data_bus_bits_o_i(bdo), .upper_data_bus_drive_i(drv),
    .upper_data_bus_bits_in_o(bdin), .upper_address_bus_bits_i(bao), .bus_clock_i(bclk),
    .ext_ready_o(xrdy), .hold_acknowledge_out_i(hold_acknowledge_out), .hold_request_in_o(xhrq),
    .upper_byte_write_strobe_i(upper_byte_write_strobe), .pad_data_i(pdi), .pad_data_o(pd_o),
    .pad_data_oe_o(pd_oe), .pad_addr_i(pai), .pad_addr_o(pa_o), .pad_addr_oe_o(pa_oe),
    .pad_ctl_i(pci), .pad_ctl_o(pc_o), .pad_ctl_oe_o(pc_oe));

  ebp_ext_model ebp_ext_model_inst (.clk_sys_i(clk), .dat_i(pd_o), .dat_oe_i(pd_oe),
    .adr_i(pa_o), .adr_oe_i(pa_oe), .ctl_i(pc_o), .ctl_oe_i(pc_oe), .mem_i(mdat),
    .mem_en_i(mdrv), .rdy_i(rdy), .hrq_i(hold_request_in), .dat_o(pdi), .adr_o(pai), .ctl_o(pci));

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic end_sim();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_up(input logic ok);
    if (!ok) begin
      num_errors++;
      end_sim();
    end
  endtask

  // Write: address and data offered together, response awaited
  task automatic axw(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s);
    logic na, nw, nb;
    int   i;
    @(posedge clk);
    awa <= a;
    wd <= v;
    ws <= s;
    {awv, wv, bry} <= 3'b111;
    nb = 1'b0;
    for (i = 0; i < 50 && !nb; i++) begin
      @(negedge clk);
      na = awv & awr;
      nw = wv & wr;
      nb = bv & bry;
      @(posedge clk);
      if (na) awv <= 1'b0;
      if (nw) wv <= 1'b0;
      if (nb) bry <= 1'b0;
    end
    give_up(nb);
  endtask

  // Read: data and response sampled at the falling edge that sees the valid response
  task automatic axr(input logic [3:0] a, output logic [31:0] v, output logic [1:0] p);
    logic na, nr;
    int   i;
    @(posedge clk);
    ara <= a;
    {arv, rry} <= 2'b11;
    nr = 1'b0;
    for (i = 0; i < 50 && !nr; i++) begin
      @(negedge clk);
      na = arv & arr;
      nr = rv & rry;
      v = rd;
      p = rr;
      @(posedge clk);
      if (na) arv <= 1'b0;
      if (nr) rry <= 1'b0;
    end
    give_up(nr);
  endtask

  // ****************************************
  // Clock and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    {rstn, awv, wv, bry, arv, rry, bclk, hold_acknowledge_out, upper_byte_write_strobe, rdy} = '0;
    {drv, mdrv, hold_request_in} = 3'b111;
    {awa, ara, ws, wd} = '0;
    {pdo, pdoe, bdo, mdat} = {8'h5a, 8'hf0, 8'ha5, 8'h3c};
    {pao, paoe, bao, pco, pcoe} = {8'hc3, 8'h00, 8'h69, 5'h15, 5'h1f};
    num_errors = 0;
    n_tests = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    axr(EBP_ADDR_CTRL, d, r);
    chk("ctrl reset", d, 32'h0);
    axr(4'hc, d, r);
    chk("unmapped data", d, 32'h0);
    chk("unmapped resp", {30'h0, r}, {30'h0, EBP_RESP_ERR});
    axw(EBP_ADDR_CTRL, 32'h1, 4'hf);
    @(negedge clk);
    chk("data 8bit", {pd_oe, pd_o}, {pdoe, pdo});
    chk("data 8bit in", {udin, bdin}, {(pdoe & pdo) | (~pdoe & mdat), 8'h00});
    axw(EBP_ADDR_CTRL, 32'h3, 4'hf);
    @(negedge clk);
    chk("data 16bit out", {pd_oe, pd_o}, {8'hff, bdo});
    @(posedge clk);
    drv <= 1'b0;
    @(negedge clk);
    chk("data 16bit in", {pd_oe, bdin}, {8'h00, mdat});
    axw(EBP_ADDR_UACTL, 32'hf, 4'hf);
    @(negedge clk);
    chk("addr split", {pa_oe, pa_o}, {8'h0f, pao[7:4], bao[3:0]});
    chk("addr pins in", uain[3:0], bao[3:0]);
    axw(EBP_ADDR_UACTL, 32'hff, 4'h0);
    axr(EBP_ADDR_UACTL, d, r);
    chk("uactl masked", d, 32'hf);
    axw(EBP_ADDR_CTRL, 32'h3f, 4'hf);
    @(negedge clk);
    chk("ctl bus", {pc_oe, pc_o & 5'h15, xrdy, xhrq}, {5'h15, 5'h00, rdy, hold_request_in});
    chk("ctl pins in", cin, {upper_byte_write_strobe, hold_request_in, hold_acknowledge_out, rdy, bclk});
    @(posedge clk);
    {bclk, hold_acknowledge_out, rdy} <= 3'b111;
    @(negedge clk);
    chk("ctl follow", {pc_o[0], pc_o[2], xrdy}, 3'b111);
    axr(EBP_ADDR_STATUS, d, r);
    chk("status", d, {29'h0, hold_acknowledge_out, hold_request_in, rdy});
    axw(EBP_ADDR_CTRL, 32'h3d, 4'hf);
    @(negedge clk);
    chk("strobe 8bit", {pc_oe[4], pc_o[4]}, {pcoe[4], pco[4]});
    axw(EBP_ADDR_CTRL, 32'h0, 4'hf);
    @(negedge clk);
    chk("ctl port", {pc_oe, pc_o, xrdy, xhrq, pa_oe, pa_o}, {pcoe, pco, 2'b10, paoe, pao});
    end_sim();
  end
endmodule
`default_nettype wire
